// ===== hsl_defines.vh
// Purpose: offsets, field positions, reset values and timing constants
//          for the secondary status and top-temperature register bank
// Assumes: 8-bit register bus, 100 MHz system clock
// Notes:   definitions only
`ifndef HSL_DEFINES_VH
`define HSL_DEFINES_VH

// register offsets
`define HSL_ADDR_SCRATCH_A 8'h97
`define HSL_ADDR_SCRATCH_B 8'h98
`define HSL_ADDR_SCRATCH_C 8'ha3
`define HSL_ADDR_READBACK_A 8'ha4
`define HSL_ADDR_FLAGS_ONE 8'ha5
`define HSL_ADDR_FLAGS_TWO 8'ha6
`define HSL_ADDR_FLAGS_THREE 8'ha7
`define HSL_ADDR_FAN_MODE 8'hab
`define HSL_ADDR_READBACK_B 8'had
`define HSL_ADDR_BOUND_Z1 8'hae
`define HSL_ADDR_BOUND_Z3 8'haf
`define HSL_ADDR_BOUND_Z2 8'hb3

// reset values
`define HSL_RST_SCRATCH_A 8'h5a
`define HSL_RST_SCRATCH_B 8'hf1
`define HSL_RST_SCRATCH_C 8'h00
`define HSL_RST_READBACK_A 8'h02
`define HSL_RST_READBACK_B 8'h00
`define HSL_RST_FLAGS 8'h00
`define HSL_RST_FAN_MODE 8'h00
`define HSL_RST_BOUND 8'h2d

// field layouts
`define HSL_F1_SUMMARY 7
`define HSL_F1_EVENT_MASK 8'h7f
`define HSL_F2_VALID_MASK 8'hdd
`define HSL_F3_VALID_MASK 8'h03
`define HSL_FAN_MODE_MASK 8'hfc
`define HSL_FAN1_HI 7
`define HSL_FAN1_LO 6
`define HSL_FAN2_HI 5
`define HSL_FAN2_LO 4
`define HSL_FAN3_HI 3
`define HSL_FAN3_LO 2

// adjustment timing
`define HSL_CLK_HZ 36'd100000000
`define HSL_SEC_PER_MIN 36'd60
`define HSL_DELAY_UNIT_MIN 36'd1
`define HSL_STEP_UNIT_C 4'd2
`define HSL_ZONES 3

`endif

// ===== hsl_status_limits.v
// Purpose: secondary status flags, fan input mode, test registers and
//          top-temperature bounds driving automatic low-limit adjustment
// Assumes: event levels and zone readings come from logic on i_sys_clk;
//          main supply good arrives from a pin
// Notes:   zone index 0 = zone 1 (remote diode 1), 1 = zone 2 (ambient),
//          2 = zone 3 (remote diode 2)
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "hsl_defines.vh"

// What this block does
// - lock makes top-temperature and two scratch test registers ignore writes
// - readback test register b reads 00 always; readback a reads 02
// - first flag register: summary, diode2, local, diode1, 5v, core, cpu, 2.5v
// - summary bit is read only; writing one does nothing
// - temperature flags clear on written one only when event gone
// - all three flag registers return to 00 on supply-good rise
// - secondary flags never raise an interrupt
// - second flag register: faults, three fan speeds, twelve volt
// - second and third flags clear on written one only when event gone
// - third flag register: battery in bit 1, standby in bit 0
// - flags set and clear exactly like their primary counterparts
// - fan mode register holds three two-bit fields, default 00
// - mode codes: normal, rotor lock high, rotor lock low, undefined
// - fan mode low two bits ignore writes and read zero
// - three top-temperature registers, default 2d each
// - top-temperature registers reload default on supply-good rise
// - reading above top with adjustment enabled lowers zone low limit
// - top value ignored unless zone adjustment enable is set
// - step code selects 2, 4, 6 or 8 degrees per adjustment
// - after adjusting, zone waits 1 to 4 minutes before next one
module hsl_status_limits #(
    parameter [35:0] P_MINUTE_CYCLES =
        `HSL_DELAY_UNIT_MIN * `HSL_SEC_PER_MIN * `HSL_CLK_HZ
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_lock,
    input wire i_main_supply_good,
    input wire [6:0] i_event_one,
    input wire [7:0] i_event_two,
    input wire [1:0] i_event_three,
    input wire [7:0] i_zone_one_temp,
    input wire [7:0] i_zone_two_temp,
    input wire [7:0] i_zone_three_temp,
    input wire [2:0] i_auto_low_limit_adjust,
    input wire [5:0] i_adjust_step_code,
    input wire [5:0] i_adjust_delay_code,
    output reg [2:0] o_adjust_pulse,
    output reg [11:0] o_adjust_amount,
    output reg [2:0] o_adjust_holdoff,
    output reg [1:0] o_fan_one_mode,
    output reg [1:0] o_fan_two_mode,
    output reg [1:0] o_fan_three_mode,
    output reg [7:0] o_upper_bound_zone_one,
    output reg [7:0] o_upper_bound_zone_two,
    output reg [7:0] o_upper_bound_zone_three
);

    // register storage
    reg [7:0] test_scratch_a_r;
    reg [7:0] test_scratch_b_r;
    reg [7:0] test_scratch_c_r;
    reg [6:0] flags_one_r;
    reg [7:0] flags_two_r;
    reg [1:0] flags_three_r;
    reg [7:0] fan_input_mode_r;
    reg [7:0] bound_r [0:2];

    // supply good synchroniser
    reg pg_s1_r;
    reg pg_s2_r;
    reg pg_s3_r;
    reg pg_level_r;
    wire pg_rise;

    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // sticky flag: event sets, written one clears only with event gone
    function [7:0] flag_next;
        input [7:0] cur;
        input [7:0] evt;
        input [7:0] clr;
        begin
            flag_next = (cur | evt) & ~(clr & ~evt);
        end
    endfunction

    // change accepted only once stages two and three agree
    assign pg_rise = pg_s2_r & pg_s3_r & ~pg_level_r;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
            pg_s3_r <= 1'b0;
            pg_level_r <= 1'b0;
        end else begin
            pg_s1_r <= i_main_supply_good;
            pg_s2_r <= pg_s1_r;
            pg_s3_r <= pg_s2_r;
            if (pg_s2_r == pg_s3_r) begin
                pg_level_r <= pg_s3_r;
            end
        end
    end

    wire wr_scr_a = wr_hit(i_addr, `HSL_ADDR_SCRATCH_A, i_wr);
    wire wr_scr_b = wr_hit(i_addr, `HSL_ADDR_SCRATCH_B, i_wr);
    wire wr_scr_c = wr_hit(i_addr, `HSL_ADDR_SCRATCH_C, i_wr);
    wire wr_f1 = wr_hit(i_addr, `HSL_ADDR_FLAGS_ONE, i_wr);
    wire wr_f2 = wr_hit(i_addr, `HSL_ADDR_FLAGS_TWO, i_wr);
    wire wr_f3 = wr_hit(i_addr, `HSL_ADDR_FLAGS_THREE, i_wr);
    wire wr_fan = wr_hit(i_addr, `HSL_ADDR_FAN_MODE, i_wr);
    wire wr_z1 = wr_hit(i_addr, `HSL_ADDR_BOUND_Z1, i_wr);
    wire wr_z2 = wr_hit(i_addr, `HSL_ADDR_BOUND_Z2, i_wr);
    wire wr_z3 = wr_hit(i_addr, `HSL_ADDR_BOUND_Z3, i_wr);

    // scratch test registers; a and b lock, c does not
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            test_scratch_a_r <= `HSL_RST_SCRATCH_A;
            test_scratch_b_r <= `HSL_RST_SCRATCH_B;
            test_scratch_c_r <= `HSL_RST_SCRATCH_C;
        end else begin
            if (wr_scr_a && !i_lock) begin
                test_scratch_a_r <= i_wdata;
            end
            if (wr_scr_b && !i_lock) begin
                test_scratch_b_r <= i_wdata;
            end
            if (wr_scr_c) begin
                test_scratch_c_r <= i_wdata;
            end
        end
    end

    // secondary flags: no interrupt path exists from here
    wire [7:0] f1_cur = {1'b0, flags_one_r};
    wire [7:0] f1_evt = {1'b0, i_event_one};
    wire [7:0] f1_clr = wr_f1 ? (i_wdata & `HSL_F1_EVENT_MASK) : 8'h00;
    wire [7:0] f1_nxt = flag_next(f1_cur, f1_evt, f1_clr);
    wire [7:0] f2_evt = i_event_two & `HSL_F2_VALID_MASK;
    wire [7:0] f2_clr = wr_f2 ? i_wdata : 8'h00;
    wire [7:0] f2_nxt = flag_next(flags_two_r, f2_evt, f2_clr)
        & `HSL_F2_VALID_MASK;
    wire [7:0] f3_evt = {6'h00, i_event_three};
    wire [7:0] f3_clr = wr_f3 ? (i_wdata & `HSL_F3_VALID_MASK) : 8'h00;
    wire [7:0] f3_nxt = flag_next({6'h00, flags_three_r}, f3_evt, f3_clr);

    // one process per bank keeps each bank's reload easy to trace
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_one_r <= 7'h00;
        end else if (pg_rise) begin
            flags_one_r <= 7'h00;
        end else begin
            flags_one_r <= f1_nxt[6:0];
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_two_r <= `HSL_RST_FLAGS;
        end else if (pg_rise) begin
            flags_two_r <= `HSL_RST_FLAGS;
        end else begin
            flags_two_r <= f2_nxt;
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_three_r <= 2'h0;
        end else if (pg_rise) begin
            flags_three_r <= 2'h0;
        end else begin
            flags_three_r <= f3_nxt[1:0];
        end
    end

    // summary mirrors the other two banks; writes never touch it
    wire summary = (|flags_two_r) | (|flags_three_r);

    // fan input mode; reserved low bits held at zero
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            fan_input_mode_r <= `HSL_RST_FAN_MODE;
        end else if (wr_fan) begin
            fan_input_mode_r <= i_wdata & `HSL_FAN_MODE_MASK;
        end
    end

    // code 11 is passed on as is; consumers treat it as undefined
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fan_one_mode <= 2'b00;
        end else begin
            o_fan_one_mode <= fan_input_mode_r[`HSL_FAN1_HI:`HSL_FAN1_LO];
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fan_two_mode <= 2'b00;
        end else begin
            o_fan_two_mode <= fan_input_mode_r[`HSL_FAN2_HI:`HSL_FAN2_LO];
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fan_three_mode <= 2'b00;
        end else begin
            o_fan_three_mode <=
                fan_input_mode_r[`HSL_FAN3_HI:`HSL_FAN3_LO];
        end
    end

    // top-temperature bounds
    wire [2:0] wr_bound = {wr_z3, wr_z2, wr_z1};
    wire [23:0] zone_temps =
        {i_zone_three_temp, i_zone_two_temp, i_zone_one_temp};

    genvar z;
    generate
        for (z = 0; z < `HSL_ZONES; z = z + 1) begin : g_zone
            reg [35:0] cyc_r;
            reg [2:0] min_r;
            wire [7:0] temp = zone_temps[z*8 +: 8];
            wire [1:0] step = i_adjust_step_code[z*2 +: 2];
            wire [1:0] dly = i_adjust_delay_code[z*2 +: 2];
            wire hold = (min_r != 3'd0);
            // bound only consulted for an enabled zone
            wire over = i_auto_low_limit_adjust[z] &&
                ($signed(temp) > $signed(bound_r[z]));

            always @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    bound_r[z] <= `HSL_RST_BOUND;
                end else if (pg_rise) begin
                    bound_r[z] <= `HSL_RST_BOUND;
                end else if (wr_bound[z] && !i_lock) begin
                    bound_r[z] <= i_wdata;
                end
            end

            always @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    cyc_r <= 36'd0;
                    min_r <= 3'd0;
                    o_adjust_pulse[z] <= 1'b0;
                    o_adjust_amount[z*4 +: 4] <= 4'd0;
                end else begin
                    o_adjust_pulse[z] <= 1'b0;
                    if (over && !hold) begin
                        o_adjust_pulse[z] <= 1'b1;
                        o_adjust_amount[z*4 +: 4] <=
                            ({2'b00, step} + 4'd1)
                            * `HSL_STEP_UNIT_C;
                        min_r <= {1'b0, dly} + 3'd1;
                        cyc_r <= P_MINUTE_CYCLES - 36'd1;
                    end else if (hold) begin
                        if (cyc_r == 36'd0) begin
                            min_r <= min_r - 3'd1;
                            cyc_r <= P_MINUTE_CYCLES - 36'd1;
                        end else begin
                            cyc_r <= cyc_r - 36'd1;
                        end
                    end
                end
            end

            always @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    o_adjust_holdoff[z] <= 1'b0;
                end else begin
                    o_adjust_holdoff[z] <= hold;
                end
            end
        end
    endgenerate

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_upper_bound_zone_one <= `HSL_RST_BOUND;
        end else begin
            o_upper_bound_zone_one <= bound_r[0];
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_upper_bound_zone_two <= `HSL_RST_BOUND;
        end else begin
            o_upper_bound_zone_two <= bound_r[1];
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_upper_bound_zone_three <= `HSL_RST_BOUND;
        end else begin
            o_upper_bound_zone_three <= bound_r[2];
        end
    end

    // unmapped offsets read zero so probing software sees no stale data
    function [7:0] rd_select;
        input [7:0] addr;
        input [7:0] scr_a;
        input [7:0] scr_b;
        input [7:0] scr_c;
        input [7:0] flags1;
        input [7:0] flags2;
        input [7:0] flags3;
        input [7:0] fan;
        input [7:0] z1;
        input [7:0] z2;
        input [7:0] z3;
        begin
            case (addr)
                `HSL_ADDR_SCRATCH_A: rd_select = scr_a;
                `HSL_ADDR_SCRATCH_B: rd_select = scr_b;
                `HSL_ADDR_SCRATCH_C: rd_select = scr_c;
                `HSL_ADDR_READBACK_A: rd_select = `HSL_RST_READBACK_A;
                `HSL_ADDR_FLAGS_ONE: rd_select = flags1;
                `HSL_ADDR_FLAGS_TWO: rd_select = flags2;
                `HSL_ADDR_FLAGS_THREE: rd_select = flags3;
                `HSL_ADDR_FAN_MODE: rd_select = fan;
                `HSL_ADDR_READBACK_B: rd_select = `HSL_RST_READBACK_B;
                `HSL_ADDR_BOUND_Z1: rd_select = z1;
                `HSL_ADDR_BOUND_Z2: rd_select = z2;
                `HSL_ADDR_BOUND_Z3: rd_select = z3;
                default: rd_select = 8'h00;
            endcase
        end
    endfunction

    // read path: data in the cycle after the strobe, otherwise zero
    wire [7:0] rd_mux = rd_select(i_addr, test_scratch_a_r,
        test_scratch_b_r, test_scratch_c_r, {summary, flags_one_r},
        flags_two_r, {6'h00, flags_three_r}, fan_input_mode_r,
        bound_r[0], bound_r[1], bound_r[2]);

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ===== hsl_status_limits_asserts.sv
// Purpose: property checks on the status and bound register bank
// Assumes: one clock; strobes stay low while reset is high
// Notes: reads judged in the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module hsl_status_limits_asserts #(
    parameter [35:0] P_MINUTE_CYCLES = 36'd20
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire i_lock,
    input wire [7:0] o_rdata,
    input wire [2:0] i_auto_low_limit_adjust,
    input wire [5:0] i_adjust_step_code,
    input wire [2:0] o_adjust_pulse,
    input wire [11:0] o_adjust_amount,
    input wire [7:0] o_upper_bound_zone_one
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    a_readback_zero: assert property ($past(i_rd) && $past(i_addr) == 8'had
        |-> o_rdata == 8'h00) else $error("readback b not zero");
    a_readback_two: assert property ($past(i_rd) && $past(i_addr) == 8'ha4
        |-> o_rdata == 8'h02) else $error("readback a not 02");
    a_fan_reserved: assert property ($past(i_rd) && $past(i_addr) == 8'hab
        |-> o_rdata[1:0] == 2'b00) else $error("fan mode low bits set");
    a_flag2_reserved: assert property ($past(i_rd) && $past(i_addr) == 8'ha6
        |-> !o_rdata[5] && !o_rdata[1]) else $error("a6 reserved set");
    a_flag3_reserved: assert property ($past(i_rd) && $past(i_addr) == 8'ha7
        |-> o_rdata[7:2] == 6'h00) else $error("a7 reserved set");
    a_lock_bound: assert property (i_wr && i_lock && i_addr == 8'hae
        |=> ##1 $stable(o_upper_bound_zone_one))
        else $error("locked bound changed");
    a_enable_gate: assert property (o_adjust_pulse != 3'b000
        |-> (o_adjust_pulse & ~$past(i_auto_low_limit_adjust)) == 3'b000)
        else $error("adjust without enable");
    a_step_amount: assert property (o_adjust_pulse[0] |-> o_adjust_amount[3:0]
        == {1'b0, $past(i_adjust_step_code[1:0]), 1'b0} + 4'd2)
        else $error("wrong adjust amount");
    a_holdoff_gap: assert property (o_adjust_pulse[0]
        |=> (!o_adjust_pulse[0]) [*8]) else $error("adjust too soon");
    c_adjust: cover property (o_adjust_pulse[0]);
    c_lock_write: cover property (i_wr && i_lock && i_addr == 8'hae);
    c_flag_read: cover property ($past(i_rd) && $past(i_addr) == 8'ha5);
endmodule
bind hsl_status_limits hsl_status_limits_asserts #(
    .P_MINUTE_CYCLES(P_MINUTE_CYCLES)) u_chk (.*);
`default_nettype wire

// ===== hsl_status_limits_tb.sv
// Purpose: self-checking bench for the status and bound register bank
// Assumes: minute shortened to 20 cycles; supply-good pin high at reset
// Notes: strobes get one idle cycle after a write call, two after a read call
`timescale 1ns/1ns
`default_nettype none
module hsl_status_limits_tb;
    localparam [35:0] MIN_CYC = 36'd20;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, lock = 1'b0;
    logic pg = 1'b1;
    logic [7:0] addr = 8'h00, wd = 8'h00, t1 = 8'h2e, t2 = 8'h10, t3 = 8'h80;
    logic [6:0] ev1 = 7'h00;
    logic [7:0] ev2 = 8'h00;
    logic [1:0] ev3 = 2'h0;
    logic [2:0] en = 3'b000;
    logic [5:0] step = 6'h00, dly = 6'h00;
    wire [7:0] rdat, b1, b2, b3;
    wire [2:0] pulse, hold;
    wire [11:0] amt;
    wire [1:0] f1, f2, f3;
    int fails = 0, n_compared = 0, cycles = 0;
    logic [7:0] ta [0:12] = '{8'h97, 8'h98, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
        8'ha7, 8'hab, 8'had, 8'hae, 8'haf, 8'hb3, 8'h99};
    logic [7:0] te [0:12] = '{8'h5a, 8'hf1, 8'h00, 8'h02, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h2d, 8'h2d, 8'h2d, 8'h00};
    always #5 clk = ~clk;
    hsl_status_limits #(.P_MINUTE_CYCLES(MIN_CYC)) dut (
        .i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdat), .i_lock(lock),
        .i_main_supply_good(pg), .i_event_one(ev1), .i_event_two(ev2),
        .i_event_three(ev3), .i_zone_one_temp(t1), .i_zone_two_temp(t2),
        .i_zone_three_temp(t3), .i_auto_low_limit_adjust(en),
        .i_adjust_step_code(step), .i_adjust_delay_code(dly),
        .o_adjust_pulse(pulse), .o_adjust_amount(amt), .o_adjust_holdoff(hold),
        .o_fan_one_mode(f1), .o_fan_two_mode(f2), .o_fan_three_mode(f3),
        .o_upper_bound_zone_one(b1), .o_upper_bound_zone_two(b2),
        .o_upper_bound_zone_three(b3));
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        cmp(rdat, exp);
    endtask
    // a hang must still reach the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        int c, k;
        logic [1:0] m;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        for (c = 0; c < 13; c++) rd(ta[c], te[c]);
        $display("test defaults done");
        wr(8'h97, 8'h33);
        wr(8'ha4, 8'hff);
        wr(8'had, 8'hff);
        wr(8'hae, 8'h40);
        wr(8'haf, 8'h41);
        wr(8'hb3, 8'h42);
        rd(8'h97, 8'h33);
        rd(8'ha4, 8'h02);
        rd(8'had, 8'h00);
        rd(8'haf, 8'h41);
        cmp(b3, 8'h41);
        cmp(b2, 8'h42);
        for (c = 0; c < 4; c++) begin
            m = c[1:0];
            wr(8'hab, {m, m, m, 2'b11});
            rd(8'hab, {m, m, m, 2'b00});
            cmp({2'b00, f1, f2, f3}, {2'b00, m, m, m});
        end
        $display("test write access done");
        @(posedge clk);
        lock <= 1'b1;
        for (c = 0; c < 6; c++) wr(c == 0 ? 8'h97 : c == 1 ? 8'h98 :
            c == 5 ? 8'ha3 : ta[c + 7], 8'ha5);
        for (c = 0; c < 3; c++) rd(ta[9 + c], 8'h40 + c[7:0]);
        rd(8'h97, 8'h33);
        rd(8'h98, 8'hf1);
        rd(8'ha3, 8'ha5);
        @(posedge clk);
        lock <= 1'b0;
        $display("test lock done");
        @(posedge clk);
        ev1 <= 7'h7f;
        ev2 <= 8'hff;
        ev3 <= 2'h3;
        rd(8'ha5, 8'hff);
        rd(8'ha6, 8'hdd);
        rd(8'ha7, 8'h03);
        wr(8'ha5, 8'hff);
        rd(8'ha5, 8'hff);
        ev1 <= 7'h00;
        ev2 <= 8'h00;
        ev3 <= 2'h0;
        wr(8'ha5, 8'h80);
        wr(8'ha6, 8'h00);
        rd(8'ha5, 8'hff);
        rd(8'ha6, 8'hdd);
        wr(8'ha5, 8'h7f);
        rd(8'ha5, 8'h80);
        wr(8'ha6, 8'hff);
        wr(8'ha7, 8'hff);
        for (c = 4; c < 7; c++) rd(ta[c], 8'h00);
        $display("test flags done");
        ev2 <= 8'h01;
        wr(8'hae, 8'h77);
        ev2 <= 8'h00;
        pg <= 1'b0;
        repeat (5) @(posedge clk);
        pg <= 1'b1;
        repeat (6) @(posedge clk);
        rd(8'ha6, 8'h00);
        rd(8'hae, 8'h2d);
        cmp(b1, 8'h2d);
        $display("test supply good done");
        @(posedge clk);
        en <= 3'b110;
        k = 0;
        repeat (40) begin
            @(posedge clk);
            k += (pulse !== 3'b000);
        end
        cmp(k[7:0], 8'h00);
        en <= 3'b111;
        for (c = 0; c < 4; c++) begin
            step <= {4'h0, c[1:0]};
            k = 0;
            while (pulse[0] !== 1'b1 && k < 200) begin
                @(posedge clk);
                k++;
            end
            cmp({7'h00, pulse[0]}, 8'h01);
            cmp({4'h0, amt[3:0]}, 8'h02 + 8'h02 * c[7:0]);
            cmp({5'h00, pulse[2:1]}, 8'h00);
            @(posedge clk);
            cmp({7'h00, hold[0]}, 8'h01);
        end
        $display("test adjust done");
        stop_test();
    end
endmodule
`default_nettype wire
